// [inc/hfc_regs.svh]
// timing counts and thresholds for the hiccup fault controller
// Notes on behaviour
// - while in hiccup both gate drive enables are held off.
// - entering hiccup starts a 5.5 ms cool-down with switching inhibited.
// - after cool-down an internal 3.6 ms soft-start ramp runs, then regulation.
// - fifteen sampled low-side over-current cycles force hiccup.
// - low-side over-current is sampled once per cycle at off interval start.
// - 32 consecutive clean cycles between limit events clear the counter.
// - high-side comparator trip above 500 mV forces hiccup.
// - under-voltage held continuously 7 us in steady state forces hiccup.
// - reference select picks the lowest of bandgap, external and internal ramp.
// - hiccup never discharges external soft-start; only reset, lockout or shutdown do.
// - hiccup entry starts cool-down and resets the internal ramp to zero.
// - during any soft-start only current-limit faults cause hiccup.
// - high-side comparator ignored for 200 nanoseconds after each high-side turn-on.
// - with low-side limit active the high-side pulse is skipped.
// - under-voltage detection armed only after soft-start has ended.
`ifndef HFC_REGS_SVH
`define HFC_REGS_SVH
`define HFC_CLK_HZ          10000000
`define HFC_COOL_US         5500
`define HFC_COOL_CYC        ((`HFC_COOL_US * (`HFC_CLK_HZ / 1000000)))
`define HFC_SS_US           3600
`define HFC_SS_CYC          ((`HFC_SS_US * (`HFC_CLK_HZ / 1000000)))
`define HFC_UV_NSEC         7000
`define HFC_UV_CYC          ((`HFC_UV_NSEC * (`HFC_CLK_HZ / 1000000) + 999) / 1000)
`define HFC_BLANK_NSEC      200
`define HFC_BLANK_CYC       ((`HFC_BLANK_NSEC * (`HFC_CLK_HZ / 1000000) + 999) / 1000)
`define HFC_LS_TRIP_CNT     15
`define HFC_CLEAN_CNT       32
`define HFC_REF_W           10
`endif

// [inc/hfc_pkg.sv]
// types for the hiccup fault controller
package hfc_pkg;
   typedef enum logic [1:0] {HFC_RUN, HFC_COOL, HFC_SOFT} hfc_state_t;
   typedef enum logic [1:0] {HFC_SRC_BG, HFC_SRC_EXT, HFC_SRC_INT} hfc_src_t;
endpackage : hfc_pkg

// [logic/hfc_hiccup_ctrl.sv]
// hiccup fault supervisor: fault counting, cool-down, internal soft-start, reference select
`timescale 1ns/1ps
`include "hfc_regs.svh"
module hfc_hiccup_ctrl #(
   parameter int COOL_CYC = `HFC_COOL_CYC,
   parameter int SS_CYC   = `HFC_SS_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 supply_lockout,
   input  wire logic                 shutdown,
   input  wire logic                 off_interval,
   input  wire logic                 hs_on_req,
   input  wire logic                 ls_on_req,
   input  wire logic                 valley_current_threshold,
   input  wire logic                 hs_overcurrent,
   input  wire logic                 output_undervoltage_trip,
   input  wire logic                 ext_ss_done,
   input  wire logic [`HFC_REF_W-1:0] bandgap_ref,
   input  wire logic [`HFC_REF_W-1:0] ext_ss_ref,
   output logic                      hs_gate_en,
   output logic                      ls_gate_en,
   output logic                      ext_ss_discharge,
   output logic                      int_ss_active,
   output logic                      in_hiccup,
   output logic [`HFC_REF_W-1:0]     ea_ref,
   output logic [1:0]                ea_ref_src
);
   localparam int CW = 16;
   localparam logic [CW-1:0] COOL_LAST = CW'(COOL_CYC - 1);
   localparam logic [CW-1:0] SS_LAST   = CW'(SS_CYC - 1);
   localparam logic [`HFC_REF_W-1:0] REF_MAX = {`HFC_REF_W{1'b1}};

   // two-flop synchronisers for every single-bit input except clk and srst
   localparam int N_SYNC = 8;
   logic [N_SYNC-1:0] s1_ff;
   logic [N_SYNC-1:0] s2_ff;
   wire  [N_SYNC-1:0] raw_in = {supply_lockout, shutdown, off_interval, hs_on_req,
                               ls_on_req, valley_current_threshold, hs_overcurrent,
                               output_undervoltage_trip};
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_ff <= '0;
         s2_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
      end
   end
   logic s_ext_done1_ff;
   logic s_ext_done2_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         s_ext_done1_ff <= 1'b0;
         s_ext_done2_ff <= 1'b0;
      end else begin
         s_ext_done1_ff <= ext_ss_done;
         s_ext_done2_ff <= s_ext_done1_ff;
      end
   end
   wire lockout_s = s2_ff[7];
   wire shut_s    = s2_ff[6];
   wire off_s     = s2_ff[5];
   wire hs_req_s  = s2_ff[4];
   wire ls_req_s  = s2_ff[3];
   wire valley_s  = s2_ff[2];
   wire hsoc_s    = s2_ff[1];
   wire uv_s      = s2_ff[0];

   function automatic logic [`HFC_REF_W-1:0] hfc_min(input logic [`HFC_REF_W-1:0] a,
                                                     input logic [`HFC_REF_W-1:0] b);
      hfc_min = (a < b) ? a : b;
   endfunction : hfc_min

   hfc_pkg::hfc_state_t state_ff;
   hfc_pkg::hfc_state_t nxt_state;
   logic [CW-1:0] tmr_ff;
   logic [CW-1:0] nxt_tmr;
   logic [`HFC_REF_W-1:0] ramp_ff;
   logic [4:0]    ls_cnt_ff;
   logic [5:0]    clean_ff;
   logic          off_d_ff;
   logic          hs_d_ff;
   logic [3:0]    blank_ff;
   logic [7:0]    uv_cnt_ff;
   logic          ls_limit_ff;

   wire stop_s    = lockout_s | shut_s;
   wire off_start = off_s & ~off_d_ff;
   wire hs_rise   = hs_req_s & ~hs_d_ff;
   wire running   = (state_ff == hfc_pkg::HFC_RUN);
   wire steady    = running & s_ext_done2_ff;
   // a sample that meets the count enters hiccup in the same cycle
   wire ls_trip   = running & off_start & valley_s & (ls_cnt_ff == 5'(`HFC_LS_TRIP_CNT - 1));
   wire hs_trip   = (running | state_ff == hfc_pkg::HFC_SOFT) & hsoc_s
                    & (blank_ff == 4'h0) & ~hs_rise;
   wire uv_trip   = steady & (uv_cnt_ff == 8'(`HFC_UV_CYC - 1)) & uv_s;
   wire ls_trip_ss = (state_ff == hfc_pkg::HFC_SOFT) & off_start & valley_s
                    & (ls_cnt_ff == 5'(`HFC_LS_TRIP_CNT - 1));
   wire enter     = ls_trip | ls_trip_ss | hs_trip | uv_trip;

   always_comb begin
      nxt_state = state_ff;
      nxt_tmr   = tmr_ff + 16'h0001;
      case (state_ff)
         hfc_pkg::HFC_RUN:  if (enter) begin
            nxt_state = hfc_pkg::HFC_COOL;
            nxt_tmr   = 16'h0000;
         end
         hfc_pkg::HFC_COOL: if (tmr_ff == COOL_LAST) begin
            nxt_state = hfc_pkg::HFC_SOFT;
            nxt_tmr   = 16'h0000;
         end
         hfc_pkg::HFC_SOFT: if (enter) begin
            nxt_state = hfc_pkg::HFC_COOL;
            nxt_tmr   = 16'h0000;
         end else if (tmr_ff == SS_LAST) begin
            nxt_state = hfc_pkg::HFC_RUN;
         end
         default: nxt_state = hfc_pkg::HFC_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst | stop_s) begin
         state_ff <= hfc_pkg::HFC_RUN;
         tmr_ff   <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         tmr_ff   <= nxt_tmr;
      end
   end

   // internal ramp: zero while cooling, full scale in run, linear in soft
   wire [`HFC_REF_W-1:0] ramp_lvl = `HFC_REF_W'((32'(tmr_ff) * 32'(REF_MAX)) / SS_CYC);
   always_ff @(posedge clk) begin
      if (srst | stop_s)
         ramp_ff <= REF_MAX;
      else if (enter | state_ff == hfc_pkg::HFC_COOL)
         ramp_ff <= '0;
      else if (state_ff == hfc_pkg::HFC_SOFT)
         ramp_ff <= ramp_lvl;
      else
         ramp_ff <= REF_MAX;
   end

   // low-side counter; cleared on hiccup entry and by a clean run
   always_ff @(posedge clk) begin
      if (srst | stop_s | enter) begin
         ls_cnt_ff <= 5'h00;
         clean_ff  <= 6'h00;
      end else if (off_start) begin
         if (valley_s) begin
            ls_cnt_ff <= ls_cnt_ff + 5'h01;
            clean_ff  <= 6'h00;
         end else if (clean_ff == 6'(`HFC_CLEAN_CNT - 1)) begin
            ls_cnt_ff <= 5'h00;
            clean_ff  <= 6'h00;
         end else begin
            clean_ff  <= clean_ff + 6'h01;
         end
      end
   end

   // edge trackers, blanking and glitch filter
   always_ff @(posedge clk) begin
      if (srst) begin
         off_d_ff    <= 1'b0;
         hs_d_ff     <= 1'b0;
         blank_ff    <= 4'h0;
         uv_cnt_ff   <= 8'h00;
         ls_limit_ff <= 1'b0;
      end else begin
         off_d_ff <= off_s;
         hs_d_ff  <= hs_req_s;
         if (hs_rise)
            blank_ff <= 4'(`HFC_BLANK_CYC);
         else if (blank_ff != 4'h0)
            blank_ff <= blank_ff - 4'h1;
         uv_cnt_ff <= (steady & uv_s & ~uv_trip) ? uv_cnt_ff + 8'h01 : 8'h00;
         // latched at off start, released once the valley falls to threshold
         if (off_start & valley_s)
            ls_limit_ff <= 1'b1;
         else if (~valley_s)
            ls_limit_ff <= 1'b0;
      end
   end

   // reference mux: smallest of the three sources
   wire [`HFC_REF_W-1:0] ref_lo = hfc_min(hfc_min(bandgap_ref, ext_ss_ref), ramp_ff);
   wire [1:0] src_sel = (ref_lo == ramp_ff && ramp_ff < bandgap_ref && ramp_ff < ext_ss_ref) ? 2'h2 :
                        (ref_lo == ext_ss_ref && ext_ss_ref < bandgap_ref) ? 2'h1 : 2'h0;
   wire hiccup_now = enter | (nxt_state == hfc_pkg::HFC_COOL);
   wire hs_ok = ~hiccup_now & ~stop_s & hs_req_s & ~ls_limit_ff & ~(off_start & valley_s);
   wire ls_ok = ~hiccup_now & ~stop_s & ls_req_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         hs_gate_en       <= 1'b0;
         ls_gate_en       <= 1'b0;
         ext_ss_discharge <= 1'b1;
         int_ss_active    <= 1'b0;
         in_hiccup        <= 1'b0;
         ea_ref           <= '0;
         ea_ref_src       <= 2'h0;
      end else begin
         hs_gate_en       <= hs_ok;
         ls_gate_en       <= ls_ok;
         ext_ss_discharge <= stop_s;
         int_ss_active    <= (nxt_state == hfc_pkg::HFC_SOFT);
         in_hiccup        <= hiccup_now;
         ea_ref           <= ref_lo;
         ea_ref_src       <= src_sel;
      end
   end

   a_hiccup_gates_off: assert property (@(posedge clk) disable iff (srst)
      state_ff == hfc_pkg::HFC_COOL |-> !hs_gate_en && !ls_gate_en)
      else $error("gate drive on during cool-down");
   a_cool_len: assert property (@(posedge clk) disable iff (srst | stop_s)
      $rose(state_ff == hfc_pkg::HFC_COOL) |-> tmr_ff == 16'h0000)
      else $error("cool-down timer not restarted");
   a_cool_to_soft: assert property (@(posedge clk) disable iff (srst | stop_s)
      state_ff == hfc_pkg::HFC_COOL && tmr_ff == COOL_LAST |=> state_ff == hfc_pkg::HFC_SOFT)
      else $error("soft-start not begun after cool-down");
   a_ls_count: assert property (@(posedge clk) disable iff (srst | stop_s)
      running && off_start && valley_s && ls_cnt_ff == 5'h0E |=> state_ff == hfc_pkg::HFC_COOL)
      else $error("fifteenth valley sample missed");
   a_sample_once: assert property (@(posedge clk) disable iff (srst | stop_s | enter)
      !off_start |=> $stable(ls_cnt_ff) || ls_cnt_ff == 5'h00)
      else $error("count moved outside off start");
   a_clean_clear: assert property (@(posedge clk) disable iff (srst | stop_s | enter)
      off_start && !valley_s && clean_ff == 6'h1F |=> ls_cnt_ff == 5'h00)
      else $error("counter not cleared after clean run");
   a_hs_trip: assert property (@(posedge clk) disable iff (srst | stop_s)
      running && hsoc_s && blank_ff == 4'h0 && !hs_rise |=> state_ff == hfc_pkg::HFC_COOL)
      else $error("high-side trip missed");
   a_uv_ignored_ss: assert property (@(posedge clk) disable iff (srst | stop_s)
      state_ff == hfc_pkg::HFC_SOFT && !hsoc_s && !valley_s |=> state_ff != hfc_pkg::HFC_COOL)
      else $error("under-voltage acted during soft-start");
   a_ref_lowest: assert property (@(posedge clk) disable iff (srst)
      ##1 ea_ref <= $past(bandgap_ref) && ea_ref <= $past(ext_ss_ref) && ea_ref <= $past(ramp_ff))
      else $error("reference not the lowest source");
   a_ext_ss_kept: assert property (@(posedge clk) disable iff (srst)
      enter && !stop_s |=> !ext_ss_discharge)
      else $error("hiccup discharged external soft-start");
   a_blank_hold: assert property (@(posedge clk) disable iff (srst)
      hs_rise |=> blank_ff == 4'h2 ##1 blank_ff == 4'h1)
      else $error("blanking interval wrong");
endmodule : hfc_hiccup_ctrl

// [testbench/hfc_pwm_model.sv]
// pwm side model: fixed-period switching with an off interval at the end of each period
`timescale 1ns/1ps
module hfc_pwm_model #(
   parameter int PERIOD = 10,
   parameter int OFF_LEN = 4
) (
   input  wire logic clk,
   input  wire logic srst,
   output logic      off_interval,
   output logic      hs_on_req,
   output logic      ls_on_req
);
   int unsigned phase_ff;
   // the requests are complementary, so the model never asks for both gates at once
   always_ff @(posedge clk) begin
      phase_ff     <= (srst || phase_ff == PERIOD - 1) ? 0 : phase_ff + 1;
      off_interval <= !srst && phase_ff >= PERIOD - OFF_LEN - 1 && phase_ff != PERIOD - 1;
      hs_on_req    <= !srst && !(phase_ff >= PERIOD - OFF_LEN - 1 && phase_ff != PERIOD - 1);
      ls_on_req    <= !srst && phase_ff >= PERIOD - OFF_LEN - 1 && phase_ff != PERIOD - 1;
   end
endmodule : hfc_pwm_model

// [testbench/tb.sv]
// self-checking bench for the hiccup fault controller
`timescale 1ns/1ps
`include "hfc_regs.svh"
module tb;
   localparam int COOL = 50;
   localparam int SS   = 40;
   logic clk = 1'b0, srst = 1'b1, supply_lockout = 1'b0, shutdown = 1'b0;
   logic valley_current_threshold = 1'b0, hs_overcurrent = 1'b0;
   logic output_undervoltage_trip = 1'b0, ext_ss_done = 1'b0;
   logic [`HFC_REF_W-1:0] bandgap_ref = 10'h300, ext_ss_ref = 10'h100, ea_ref;
   logic off_interval, hs_on_req, ls_on_req, hs_gate_en, ls_gate_en;
   logic ext_ss_discharge, int_ss_active, in_hiccup;
   logic [1:0] ea_ref_src;
   int n_errors = 0, checks = 0;
   always #50 clk = ~clk;
   hfc_pwm_model hfc_pwm_model_i (.clk(clk), .srst(srst), .off_interval(off_interval),
      .hs_on_req(hs_on_req), .ls_on_req(ls_on_req));
   hfc_hiccup_ctrl #(.COOL_CYC(COOL), .SS_CYC(SS)) hfc_hiccup_ctrl_i (.clk(clk), .srst(srst),
      .supply_lockout(supply_lockout), .shutdown(shutdown), .off_interval(off_interval),
      .hs_on_req(hs_on_req), .ls_on_req(ls_on_req), .valley_current_threshold(valley_current_threshold),
      .hs_overcurrent(hs_overcurrent), .output_undervoltage_trip(output_undervoltage_trip),
      .ext_ss_done(ext_ss_done), .bandgap_ref(bandgap_ref), .ext_ss_ref(ext_ss_ref),
      .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en), .ext_ss_discharge(ext_ss_discharge),
      .int_ss_active(int_ss_active), .in_hiccup(in_hiccup), .ea_ref(ea_ref), .ea_ref_src(ea_ref_src));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   // watch up to lim cycles and note whether hiccup was seen anywhere in them
   // returns at the first sample that shows hiccup, so the caller can time what follows
   task automatic wait_hic(input int lim, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < lim && hit == 1'b0; i++) begin
         @(posedge clk);
         if (in_hiccup === 1'b1) hit = 1'b1;
      end
   endtask : wait_hic
   // count cycles while a level stays high; a stuck level ends the run
   task automatic run_len(input logic sel, output int n, output logic gates);
      n = 0;
      gates = 1'b0;
      while ((sel ? int_ss_active : in_hiccup) === 1'b1) begin
         gates = gates | hs_gate_en | ls_gate_en | ext_ss_discharge;
         n++;
         if (n > 300) begin n_errors++; wrap_up(); end
         @(posedge clk);
      end
   endtask : run_len
   task automatic ls_burst(input int n);
      valley_current_threshold <= 1'b1;
      repeat (n) @(posedge off_interval);
      @(posedge clk);
      valley_current_threshold <= 1'b0;
   endtask : ls_burst
   // full hiccup: cool-down with gates off, then internal ramp from its discharged level
   task automatic t_hiccup;
      logic h, g;
      int n;
      wait_hic(20, h);
      if (h !== 1'b1) begin n_errors++; wrap_up(); end
      run_len(1'b0, n, g);
      chk(16'(g), 16'h0);
      chk(16'(n >= COOL - 1 && n <= COOL + 2), 16'h1);
      chk(16'(ea_ref_src), 16'h2);
      run_len(1'b1, n, g);
      chk(16'(n >= SS - 1 && n <= SS + 2), 16'h1);
      repeat (10) @(posedge clk);
      $display("hiccup cycle done");
   endtask : t_hiccup
   task automatic t_ls;
      logic h;
      ls_burst(14);
      wait_hic(25, h);
      chk(16'(h), 16'h0);
      ls_burst(1);
      t_hiccup();
      ls_burst(14);
      wait_hic(25, h);
      chk(16'(h), 16'h0);
      ls_burst(1);
      t_hiccup();
      ls_burst(14);
      repeat (400) @(posedge clk);
      ls_burst(14);
      wait_hic(25, h);
      chk(16'(h), 16'h0);
      ls_burst(1);
      t_hiccup();
      $display("low-side count test done");
   endtask : t_ls
   task automatic t_hs;
      logic h;
      @(posedge hs_on_req);
      // trip held through the turn-on cycle and both blanking cycles, no longer
      hs_overcurrent <= 1'b1;
      repeat (3) @(posedge clk);
      hs_overcurrent <= 1'b0;
      wait_hic(20, h);
      chk(16'(h), 16'h0);
      @(posedge hs_on_req);
      repeat (4) @(posedge clk);
      hs_overcurrent <= 1'b1;
      @(posedge clk);
      hs_overcurrent <= 1'b0;
      t_hiccup();
      $display("high-side test done");
   endtask : t_hs
   // valley held over several off intervals: the high-side pulse stays skipped until it drops
   task automatic t_skip;
      logic hs_seen, ls_seen;
      hs_seen = 1'b0;
      ls_seen = 1'b0;
      valley_current_threshold <= 1'b1;
      @(posedge off_interval);
      repeat (4) @(posedge clk);
      repeat (20) begin
         @(posedge clk);
         if (hs_gate_en !== 1'b0) hs_seen = 1'b1;
      end
      valley_current_threshold <= 1'b0;
      chk(16'(hs_seen), 16'h0);
      repeat (20) begin
         @(posedge clk);
         if (hs_gate_en === 1'b1) hs_seen = 1'b1;
         if (ls_gate_en === 1'b1) ls_seen = 1'b1;
      end
      chk(16'({hs_seen, ls_seen}), 16'h3);
      $display("high-side skip test done");
   endtask : t_skip
   task automatic t_uv;
      logic h;
      output_undervoltage_trip <= 1'b1;
      wait_hic(100, h);
      chk(16'(h), 16'h0);
      output_undervoltage_trip <= 1'b0;
      ext_ss_done <= 1'b1;
      repeat (5) @(posedge clk);
      output_undervoltage_trip <= 1'b1;
      wait_hic(60, h);
      chk(16'(h), 16'h0);
      // a one-cycle gap must restart the glitch filter from zero
      output_undervoltage_trip <= 1'b0;
      @(posedge clk);
      output_undervoltage_trip <= 1'b1;
      wait_hic(60, h);
      chk(16'(h), 16'h0);
      t_hiccup();
      output_undervoltage_trip <= 1'b0;
      $display("under-voltage test done");
   endtask : t_uv
   task automatic t_ref;
      repeat (5) @(posedge clk);
      chk(16'(ea_ref), 16'h0100);
      chk(16'(ea_ref_src), 16'h1);
      bandgap_ref <= 10'h080;
      repeat (5) @(posedge clk);
      chk(16'(ea_ref), 16'h0080);
      chk(16'(ea_ref_src), 16'h0);
      bandgap_ref <= 10'h300;
      supply_lockout <= 1'b1;
      repeat (5) @(posedge clk);
      chk(16'({ext_ss_discharge, hs_gate_en, ls_gate_en}), 16'h4);
      supply_lockout <= 1'b0;
      shutdown <= 1'b1;
      repeat (5) @(posedge clk);
      chk(16'(ext_ss_discharge), 16'h1);
      shutdown <= 1'b0;
      repeat (5) @(posedge clk);
      chk(16'(ext_ss_discharge), 16'h0);
      $display("reference and lockout test done");
   endtask : t_ref
   initial begin
      repeat (20) @(posedge clk);
      chk(16'({ext_ss_discharge, hs_gate_en, ls_gate_en}), 16'h4);
      srst <= 1'b0;
      repeat (10) @(posedge clk);
      t_ref();
      t_ls();
      t_hs();
      t_skip();
      t_uv();
      wrap_up();
   end
endmodule : tb
